// ---- rotate_right_no_carry_exec_tb.sv ----
// Self-checking bench for the rotate execution block
`timescale 1ns/100ps
module rotate_right_no_carry_exec_tb;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic op_valid_i = 1'b0;
	logic [15:0] opcode_i = 16'h0000;
	logic ext_set_en_i = 1'b0;
	logic [3:0] bank_select_reg_i = 4'h3;
	logic [11:0] index_base_i = 12'h100;
	logic [7:0] mem_rdata_i, mem_wdata_o, wreg_o;
	logic ready_o, op_accept_o, mem_rd_o, mem_wr_o, wreg_wr_o;
	logic neg_flag_o, zero_flag_o, flag_wr_o, indexed_o, done_o;
	logic [2:0] phase_o;
	logic [11:0] mem_addr_o;
	int n_fail = 0;
	int checks_done = 0;
	always #2 clock_i = ~clock_i;
	rrnc_exec #(.ADDR_W(12)) u_dut (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.op_valid_i(op_valid_i),
		.opcode_i(opcode_i),
		.ext_set_en_i(ext_set_en_i),
		.bank_select_reg_i(bank_select_reg_i),
		.index_base_i(index_base_i),
		.mem_rdata_i(mem_rdata_i),
		.ready_o(ready_o),
		.op_accept_o(op_accept_o),
		.phase_o(phase_o),
		.mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o),
		.mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o),
		.wreg_o(wreg_o),
		.wreg_wr_o(wreg_wr_o),
		.neg_flag_o(neg_flag_o),
		.zero_flag_o(zero_flag_o),
		.flag_wr_o(flag_wr_o),
		.indexed_o(indexed_o),
		.done_o(done_o)
	);
	rrnc_mem_model u_mem (.clock_i(clock_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
		.wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	// One instruction: preload, offer the word, follow the four phases
	task automatic op(input logic [15:0] w, input logic [11:0] ea, input logic ix,
		input logic [7:0] din);
		logic [7:0] r;
		r = {din[0], din[7:1]};
		u_mem.mem[ea] = din;
		opcode_i = w;
		op_valid_i = 1'b1;
		@(negedge clock_i);
		op_valid_i = 1'b0;
		chk({ready_o, op_accept_o, phase_o}, {1'b0, 1'b1, 3'h1});
		@(negedge clock_i);
		chk(mem_addr_o, ea);
		chk(indexed_o, ix);
		chk({mem_rd_o, phase_o}, {1'b1, 3'h2});
		repeat (2) @(negedge clock_i);
		chk({mem_wr_o, wreg_wr_o, done_o, flag_wr_o}, {w[9], !w[9], 1'b1, 1'b1});
		chk(w[9] ? mem_wdata_o : wreg_o, r);
		chk({neg_flag_o, zero_flag_o}, {r[7], r == 8'h00});
		@(negedge clock_i);
		chk(u_mem.mem[ea], w[9] ? r : din);
		chk({ready_o, phase_o}, 4'h8);
	endtask : op
	// Both destinations on one byte, back to back
	task automatic t_dest();
		op(16'h4312, 12'h312, 1'b0, 8'hD7);
		op(16'h4112, 12'h312, 1'b0, 8'hD7);
		$display("t_dest done");
	endtask : t_dest
	// Word of another group is ignored
	task automatic t_refuse();
		opcode_i = 16'h4412;
		op_valid_i = 1'b1;
		repeat (2) @(negedge clock_i);
		op_valid_i = 1'b0;
		chk({ready_o, op_accept_o, phase_o}, 5'h10);
		// Let an edge pass so the next offer does not raise valid in this time step
		@(negedge clock_i);
		$display("t_refuse done");
	endtask : t_refuse
	// Access bank halves, bank register, indexed edge at 5Fh
	task automatic t_bank();
		op(16'h4080, 12'hF80, 1'b0, 8'h01);
		op(16'h4020, 12'h020, 1'b0, 8'h00);
		ext_set_en_i = 1'b1;
		op(16'h405F, 12'h15F, 1'b1, 8'h80);
		op(16'h4060, 12'hF60, 1'b0, 8'hFF);
		op(16'h4105, 12'h305, 1'b0, 8'h02);
		ext_set_en_i = 1'b0;
		$display("t_bank done");
	endtask : t_bank
	// Ceiling well above the 41 or so cycles the run needs
	initial begin
		repeat (500) @(posedge clock_i);
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (3) @(negedge clock_i);
		nrst_i = 1'b1;
		t_dest();
		t_refuse();
		t_bank();
		print_verdict();
	end
endmodule : rotate_right_no_carry_exec_tb

// ---- rrnc_addr_gen.sv ----
// Operand address formation for the rotate execution block
`timescale 1ns/100ps
`include "rrnc_consts.svh"

module rrnc_addr_gen #(
	parameter int ADDR_W = 12
) (
	input wire logic [7:0] file_addr_i,
	input wire logic acc_sel_i,
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_reg_i,
	input wire logic [ADDR_W-1:0] index_base_i,
	output logic [ADDR_W-1:0] addr_o,
	output logic indexed_o
);

	logic low_part;

	// Low part of the access bank sits in bank 0, the rest in the top bank
	assign low_part = (file_addr_i <= `RRNC_ACC_LIMIT);
	assign indexed_o = ext_set_en_i && !acc_sel_i && low_part;

	// Indexed mode wins over the plain access bank; the bank register only counts with a=1
	always_comb begin
		if (indexed_o) begin
			addr_o = index_base_i + {{(ADDR_W-8){1'b0}}, file_addr_i};
		end else if (acc_sel_i) begin
			addr_o = ADDR_W'({bank_select_reg_i, file_addr_i});
		end else if (low_part) begin
			addr_o = ADDR_W'({`RRNC_ACC_LO_BANK, file_addr_i});
		end else begin
			addr_o = ADDR_W'({`RRNC_ACC_HI_BANK, file_addr_i});
		end
	end

endmodule : rrnc_addr_gen

// ---- rrnc_consts.svh ----
// Constants for the rotate-right-without-carry execution block
`ifndef RRNC_CONSTS_SVH
`define RRNC_CONSTS_SVH

// Opcode layout: six fixed bits, destination bit, bank access bit, 8-bit address
`define RRNC_OPC_MATCH 6'h10
`define RRNC_OPC_HI 15
`define RRNC_OPC_LO 10
`define RRNC_DEST_BIT 9
`define RRNC_ACC_BIT 8
`define RRNC_ADDR_HI 7
`define RRNC_ADDR_LO 0

// Result bit positions
`define RRNC_MSB 7
`define RRNC_LSB 0

// Access bank split and the bank that holds its upper part
`define RRNC_ACC_LIMIT 8'h5F
`define RRNC_ACC_HI_BANK 4'hF
`define RRNC_ACC_LO_BANK 4'h0

// Reset values
`define RRNC_RST_BYTE 8'h00
`define RRNC_RST_ADDR 12'h000
`define RRNC_RST_OPC 16'h0000

`endif

// ---- rrnc_exec.sv ----
// Execution datapath for the rotate-right-without-carry byte instruction
`timescale 1ns/100ps
`include "rrnc_consts.svh"

module rrnc_exec
	import rrnc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic op_valid_i,
	input wire logic [15:0] opcode_i,
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_reg_i,
	input wire logic [ADDR_W-1:0] index_base_i,
	input wire logic [7:0] mem_rdata_i,
	output logic ready_o,
	output logic op_accept_o,
	output logic [2:0] phase_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o,
	output logic [7:0] wreg_o,
	output logic wreg_wr_o,
	output logic neg_flag_o,
	output logic zero_flag_o,
	output logic flag_wr_o,
	output logic indexed_o,
	output logic done_o
);

	rrnc_phase_t phase;
	rrnc_phase_t next_phase;
	logic [15:0] opcode;
	logic [15:0] next_opcode;
	logic is_rotate;
	logic dest_sel;
	logic acc_sel;
	logic [7:0] file_addr;
	logic [ADDR_W-1:0] calc_addr;
	logic calc_indexed;
	logic [7:0] rotated;

	logic next_ready;
	logic next_op_accept;
	logic [ADDR_W-1:0] next_mem_addr;
	logic next_mem_rd;
	logic next_mem_wr;
	logic [7:0] next_mem_wdata;
	logic [7:0] next_wreg;
	logic next_wreg_wr;
	logic next_neg_flag;
	logic next_zero_flag;
	logic next_flag_wr;
	logic next_indexed;
	logic next_done;

	// Opcode match is on the incoming word; anything else is simply not taken
	assign is_rotate = (opcode_i[`RRNC_OPC_HI:`RRNC_OPC_LO] == `RRNC_OPC_MATCH);

	// Fields come from the latched opcode so the bus may change after acceptance
	assign dest_sel = opcode[`RRNC_DEST_BIT];
	assign acc_sel = opcode[`RRNC_ACC_BIT];
	assign file_addr = opcode[`RRNC_ADDR_HI:`RRNC_ADDR_LO];

	// Rotate by one with bit 0 wrapping to bit 7; carry takes no part
	assign rotated = {mem_rdata_i[`RRNC_LSB], mem_rdata_i[`RRNC_MSB:1]};

	// Address formation kept apart so other byte instructions can share it
	rrnc_addr_gen #(
		.ADDR_W(ADDR_W)
	) u_addr_gen (
		.file_addr_i(file_addr),
		.acc_sel_i(acc_sel),
		.ext_set_en_i(ext_set_en_i),
		.bank_select_reg_i(bank_select_reg_i),
		.index_base_i(index_base_i),
		.addr_o(calc_addr),
		.indexed_o(calc_indexed)
	);

	// Phase sequencer: a taken opcode walks Q1 to Q4 and returns to idle
	always_comb begin
		next_phase = phase;
		next_opcode = opcode;
		next_op_accept = 1'b0;
		unique case (phase)
			RRNC_IDLE: begin
				if (op_valid_i && is_rotate) begin
					next_phase = RRNC_Q1;
					next_opcode = opcode_i;
					next_op_accept = 1'b1;
				end
			end
			RRNC_Q1: begin
				next_phase = RRNC_Q2;
			end
			RRNC_Q2: begin
				next_phase = RRNC_Q3;
			end
			RRNC_Q3: begin
				next_phase = RRNC_Q4;
			end
			RRNC_Q4: begin
				next_phase = RRNC_IDLE;
			end
			default: begin
				next_phase = RRNC_IDLE;
			end
		endcase
		next_ready = (next_phase == RRNC_IDLE);
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			phase <= RRNC_IDLE;
			opcode <= `RRNC_RST_OPC;
			ready_o <= 1'b1;
			op_accept_o <= 1'b0;
			phase_o <= RRNC_IDLE;
		end else begin
			phase <= next_phase;
			opcode <= next_opcode;
			ready_o <= next_ready;
			op_accept_o <= next_op_accept;
			phase_o <= next_phase;
		end
	end

	// Memory side: address is taken in Q1 and stands with the read strobe in Q2, write strobe in Q4
	always_comb begin
		next_mem_addr = mem_addr_o;
		next_mem_rd = 1'b0;
		next_mem_wr = 1'b0;
		next_mem_wdata = mem_wdata_o;
		next_indexed = indexed_o;
		unique case (phase)
			RRNC_Q1: begin
				next_mem_addr = calc_addr;
				next_indexed = calc_indexed;
				next_mem_rd = 1'b1;
			end
			RRNC_Q3: begin
				if (dest_sel) begin
					next_mem_wr = 1'b1;
					next_mem_wdata = rotated;
				end
			end
			RRNC_IDLE, RRNC_Q2, RRNC_Q4: begin
				next_mem_rd = 1'b0;
			end
			default: begin
				next_mem_rd = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			mem_addr_o <= ADDR_W'(`RRNC_RST_ADDR);
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_wdata_o <= `RRNC_RST_BYTE;
			indexed_o <= 1'b0;
		end else begin
			mem_addr_o <= next_mem_addr;
			mem_rd_o <= next_mem_rd;
			mem_wr_o <= next_mem_wr;
			mem_wdata_o <= next_mem_wdata;
			indexed_o <= next_indexed;
		end
	end

	// Working register and status flags, both committed into Q4
	// Memory is never written when the working register is the target
	always_comb begin
		next_wreg = wreg_o;
		next_wreg_wr = 1'b0;
		next_neg_flag = neg_flag_o;
		next_zero_flag = zero_flag_o;
		next_flag_wr = 1'b0;
		next_done = 1'b0;
		if (phase == RRNC_Q3) begin
			if (!dest_sel) begin
				next_wreg = rotated;
				next_wreg_wr = 1'b1;
			end
			// Only N and Z are driven; the core keeps C, DC and OV as they were
			next_neg_flag = rotated[`RRNC_MSB];
			next_zero_flag = (rotated == `RRNC_RST_BYTE);
			next_flag_wr = 1'b1;
			next_done = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			wreg_o <= `RRNC_RST_BYTE;
			wreg_wr_o <= 1'b0;
			neg_flag_o <= 1'b0;
			zero_flag_o <= 1'b0;
			flag_wr_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			wreg_o <= next_wreg;
			wreg_wr_o <= next_wreg_wr;
			neg_flag_o <= next_neg_flag;
			zero_flag_o <= next_zero_flag;
			flag_wr_o <= next_flag_wr;
			done_o <= next_done;
		end
	end

endmodule : rrnc_exec

// ---- rrnc_exec_assertions.sv ----
// Checker for the rotate execution block
`timescale 1ns/100ps
module rrnc_exec_assertions (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic op_valid_i,
	input wire logic [15:0] opcode_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic ready_o,
	input wire logic op_accept_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic [7:0] wreg_o,
	input wire logic wreg_wr_o,
	input wire logic neg_flag_o,
	input wire logic zero_flag_o,
	input wire logic flag_wr_o,
	input wire logic done_o
);
	logic [7:0] rd_q;
	logic [7:0] rot;
	// Q3 operand kept so the Q4 result can be judged against it
	always_ff @(posedge clock_i) rd_q <= mem_rdata_i;
	assign rot = {rd_q[0], rd_q[7:1]};
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	sequence s_take; ready_o && op_valid_i && opcode_i[15:10] == 6'h10; endsequence
	sequence s_run; mem_rd_o ##1 !mem_rd_o ##1 done_o; endsequence
	property p_take; s_take |=> op_accept_o; endproperty
	a_take: assert property (p_take) else $error("take");
	property p_phase; op_accept_o |=> s_run; endproperty
	a_phase: assert property (p_phase) else $error("phase");
	property p_busy; op_accept_o |-> !ready_o [*4] ##1 ready_o; endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_rot; flag_wr_o |-> (mem_wr_o ? mem_wdata_o : wreg_o) == rot; endproperty
	a_rot: assert property (p_rot) else $error("rotate");
	property p_flag; flag_wr_o |-> neg_flag_o == rot[7] && zero_flag_o == (rot == 8'h00); endproperty
	a_flag: assert property (p_flag) else $error("flags");
	// Flags move only with their strobe
	property p_keep; !flag_wr_o |-> $stable({neg_flag_o, zero_flag_o}); endproperty
	a_keep: assert property (p_keep) else $error("flag hold");
	property p_file; s_take ##0 opcode_i[9] |-> ##4 mem_wr_o && !wreg_wr_o; endproperty
	a_file: assert property (p_file) else $error("file dest");
	property p_wreg; s_take ##0 !opcode_i[9] |-> ##4 wreg_wr_o && !mem_wr_o; endproperty
	a_wreg: assert property (p_wreg) else $error("w dest");
endmodule : rrnc_exec_assertions
bind rrnc_exec rrnc_exec_assertions u_chk (
	.clock_i(clock_i),
	.nrst_i(nrst_i),
	.op_valid_i(op_valid_i),
	.opcode_i(opcode_i),
	.mem_rdata_i(mem_rdata_i),
	.ready_o(ready_o),
	.op_accept_o(op_accept_o),
	.mem_rd_o(mem_rd_o),
	.mem_wr_o(mem_wr_o),
	.mem_wdata_o(mem_wdata_o),
	.wreg_o(wreg_o),
	.wreg_wr_o(wreg_wr_o),
	.neg_flag_o(neg_flag_o),
	.zero_flag_o(zero_flag_o),
	.flag_wr_o(flag_wr_o),
	.done_o(done_o)
);

// ---- rrnc_mem_model.sv ----
// Data memory answering operand reads and writes
`timescale 1ns/100ps
module rrnc_mem_model (
	input wire logic clock_i,
	input wire logic [11:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o = 8'h00
);
	logic [7:0] mem [4096];
	// Data only in Q3; elsewhere inverted so a late sample never looks valid
	always @(posedge clock_i) begin
		rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
		if (wr_i) mem[addr_i] <= wdata_i;
	end
endmodule : rrnc_mem_model

// ---- rrnc_pkg.sv ----
// Types shared by the rotate-right-without-carry execution block
package rrnc_pkg;

	// One idle state plus the four phases of an instruction cycle
	typedef enum logic [2:0] {
		RRNC_IDLE = 3'b000,
		RRNC_Q1 = 3'b001,
		RRNC_Q2 = 3'b010,
		RRNC_Q3 = 3'b011,
		RRNC_Q4 = 3'b100
	} rrnc_phase_t;

endpackage : rrnc_pkg
